// File: include/tmc_pkg.sv
// Purpose: constants, types and register map of the timer modulo and
//   channel control block
// Assumes: byte-wide register port, one register per address
// Notes: register addresses are local to this block
// Function
// (RL1) debug mode freezes the counter and its byte-read coherency latch
// (RL2) counter at terminal sets wrap flag, then wraps to zero or turns down
// (RL3) writing one terminal byte blocks wrap flag until other byte written
// (RL4) terminal value resets to zero; zero means free run over 16 bits
// (RL5) software should rewrite terminal soon after a wrap or reset counter
// (RL6) capture mode sets event flag on the selected active pin edge
// (RL7) compare or edge pwm sets event flag when counter equals channel value
// (RL8) center pwm sets event flag on every counter match, up and down
// (RL9) channel interrupt asserted while event flag set and enable is one
// (RL10) flag clears only by a read while set then a write of zero
// (RL11) a new event during the clear sequence restarts it and keeps flag
// (RL12) writing one to event flag does nothing; reset clears the flag
// (RL13) channel interrupt enable is read/write bit 6, cleared by reset
// (RL14) center pwm off and mode bit 5 high gives edge-aligned pwm
// (RL15) otherwise mode bit 4 picks input capture (0) or output compare (1)
// (RL16) edge/level bits 3:2 pick capture edge, compare level or pwm polarity
// (RL17) edge/level 00 releases the channel pin from timer functions
// (RL18) center pwm select forces every channel into center-aligned pwm
// (RL19) capture edge codes 01, 10, 11 mean rising, falling, either edge
package tmc_pkg;
  localparam int ADDR_W = 6;
  localparam int DATA_W = 8;
  localparam int CNT_W = 16;

  // register addresses
  localparam logic [ADDR_W-1:0] ADDR_TSC = 6'h00;
  localparam logic [ADDR_W-1:0] ADDR_CNT_HI = 6'h01;
  localparam logic [ADDR_W-1:0] ADDR_CNT_LO = 6'h02;
  localparam logic [ADDR_W-1:0] ADDR_MOD_HI = 6'h03;
  localparam logic [ADDR_W-1:0] ADDR_MOD_LO = 6'h04;
  localparam logic [ADDR_W-1:0] ADDR_IRQ_STAT = 6'h05;
  localparam logic [ADDR_W-1:0] ADDR_IRQ_MASK = 6'h06;
  localparam logic [ADDR_W-1:0] ADDR_CH_BASE = 6'h08;
  localparam logic [ADDR_W-1:0] ADDR_CH_STRIDE = 6'h04;
  localparam logic [ADDR_W-1:0] CH_OFF_SC = 6'h00;
  localparam logic [ADDR_W-1:0] CH_OFF_VAL_HI = 6'h01;
  localparam logic [ADDR_W-1:0] CH_OFF_VAL_LO = 6'h02;

  // bit positions
  localparam int FLAG_BIT = 7;
  localparam int IE_BIT = 6;
  localparam int CPWM_BIT = 5;
  localparam int RUN_BIT = 0;
  localparam int MS_UPPER_BIT = 5;
  localparam int MS_LOWER_BIT = 4;
  localparam int ELS_HI_BIT = 3;
  localparam int ELS_LO_BIT = 2;
  localparam int STAT_OVF_BIT = 0;
  localparam int STAT_CH_BASE = 1;

  // edge/level codes
  localparam logic [1:0] ELS_OFF = 2'h0;
  localparam logic [1:0] ELS_01 = 2'h1;
  localparam logic [1:0] ELS_10 = 2'h2;
  localparam logic [1:0] ELS_11 = 2'h3;

  // values
  localparam logic [CNT_W-1:0] CNT_ZERO = 16'h0000;
  localparam logic [CNT_W-1:0] CNT_ONE = 16'h0001;
  localparam logic [CNT_W-1:0] CNT_FULL = 16'hFFFF;
  localparam logic [CNT_W-1:0] MOD_RESET = 16'h0000;
  localparam logic [DATA_W-1:0] BYTE_ZERO = 8'h00;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } tmc_bus_req_s;

  typedef struct packed {
    logic irq_en;
    logic mode_upper;
    logic mode_lower;
    logic [1:0] edge_level;
  } tmc_ch_ctrl_s;

  typedef enum {
    MODE_CAPTURE,
    MODE_COMPARE,
    MODE_EDGE_PWM,
    MODE_CENTER_PWM
  } tmc_mode_e;
endpackage : tmc_pkg

// File: core/tmc_timer_core.sv
// Purpose: 16-bit timer counter with terminal value, wrap flag and
//   capture/compare/pwm channels
// Assumes: one count per clock while running; pins synchronous to clock
// Notes: clear-sequence flags let a new event win over the clear
module tmc_timer_core #(
  parameter int NUM_CH = 2
) (
  input wire logic CLK_IN,
  input wire logic SYS_RST_IN,
  input wire logic DEBUG_MODE_IN,
  input wire tmc_pkg::tmc_bus_req_s BUS_IN,
  output logic [tmc_pkg::DATA_W-1:0] RD_DATA_OUT,
  input wire logic [NUM_CH-1:0] CH_PIN_IN,
  output logic [NUM_CH-1:0] CH_PIN_OUT,
  output logic [NUM_CH-1:0] CH_PIN_OE_OUT,
  output logic [NUM_CH-1:0] CH_IRQ_OUT,
  output logic OVF_IRQ_OUT,
  output logic IRQ_OUT
);
  import tmc_pkg::*;

  // status byte holds the wrap bit plus one bit per channel
  if (NUM_CH < 1 || NUM_CH > DATA_W - STAT_CH_BASE) begin : g_bad_num_ch
    $error("NUM_CH must be 1 to 7");
  end

  // true when the address hits register off of channel n
  function automatic logic ch_hit(input logic [ADDR_W-1:0] a, input int n,
                                  input logic [ADDR_W-1:0] off);
    return a == ADDR_W'(ADDR_CH_BASE + ADDR_CH_STRIDE * n + off);
  endfunction : ch_hit

  // channel mode from the global center select and channel mode bits
  function automatic tmc_mode_e ch_mode(input logic cpwm,
                                        input tmc_ch_ctrl_s c);
    if (cpwm) begin
      return MODE_CENTER_PWM; // see (RL18)
    end else if (c.mode_upper) begin
      return MODE_EDGE_PWM; // see (RL14)
    end else if (c.mode_lower) begin
      return MODE_COMPARE; // see (RL15)
    end else begin
      return MODE_CAPTURE; // see (RL15)
    end
  endfunction : ch_mode

  // counter, terminal, flag and register state
  logic [CNT_W-1:0] cnt, mod, cnt_buf, terminal, cnt_view;
  logic count_down, mod_pend_hi, mod_pend_lo, cpwm, run;
  logic ovf_flag, ovf_armed, ovf_ie, cnt_latched, cnt_first_hi;
  logic [DATA_W-1:0] irq_stat, irq_mask, rd_data, next_rd, next_stat_set;
  logic [DATA_W-1:0] ch_sc_rd [NUM_CH];
  logic [CNT_W-1:0] ch_val_rd [NUM_CH];
  logic [NUM_CH-1:0] ch_event;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wdata;
  logic wr, rd, tsc_wr, tsc_rd, cnt_wr, cnt_rd_hi, cnt_rd_lo;
  logic step, at_term, wrap_step, ovf_set;

  // bus request fields and fixed register decodes
  assign wr = BUS_IN.wr;
  assign rd = BUS_IN.rd;
  assign addr = BUS_IN.addr;
  assign wdata = BUS_IN.wdata;
  assign tsc_wr = wr && addr == ADDR_TSC;
  assign tsc_rd = rd && addr == ADDR_TSC;
  assign cnt_wr = wr && (addr == ADDR_CNT_HI || addr == ADDR_CNT_LO);
  assign cnt_rd_hi = rd && addr == ADDR_CNT_HI;
  assign cnt_rd_lo = rd && addr == ADDR_CNT_LO;

  // counting stops in debug mode, so matches and wraps stop with it
  assign step = run && !DEBUG_MODE_IN; // see (RL1)
  assign terminal = (mod == MOD_RESET) ? CNT_FULL : mod; // see (RL4)
  assign at_term = cnt == terminal;
  // in center mode the wrap counts at the turn from terminal downward
  assign wrap_step = step && at_term && !count_down;
  assign ovf_set = wrap_step && !(mod_pend_hi || mod_pend_lo); // see (RL3)

  // main counter, up or up/down
  always_ff @(posedge CLK_IN) begin
    if (SYS_RST_IN) begin
      cnt <= CNT_ZERO;
      count_down <= 1'b0;
    end else if (cnt_wr) begin
      cnt <= CNT_ZERO;
      count_down <= 1'b0;
    end else if (step) begin
      if (!cpwm) begin
        cnt <= at_term ? CNT_ZERO : cnt + CNT_ONE; // see (RL2)
        count_down <= 1'b0;
      end else if (count_down) begin
        if (cnt == CNT_ZERO) begin
          cnt <= cnt + CNT_ONE;
          count_down <= 1'b0;
        end else begin
          cnt <= cnt - CNT_ONE;
        end
      end else if (at_term) begin
        cnt <= cnt - CNT_ONE; // see (RL2)
        count_down <= 1'b1;
      end else begin
        cnt <= cnt + CNT_ONE;
      end
    end
  end

  // terminal value bytes; a lone byte write holds off the wrap flag
  always_ff @(posedge CLK_IN) begin
    if (SYS_RST_IN) begin
      mod <= MOD_RESET; // see (RL4)
      mod_pend_hi <= 1'b0;
      mod_pend_lo <= 1'b0;
    end else if (wr && addr == ADDR_MOD_HI) begin
      mod[CNT_W-1:DATA_W] <= wdata;
      mod_pend_hi <= !mod_pend_lo; // see (RL3)
      mod_pend_lo <= 1'b0;
    end else if (wr && addr == ADDR_MOD_LO) begin
      mod[DATA_W-1:0] <= wdata;
      mod_pend_lo <= !mod_pend_hi; // see (RL3)
      mod_pend_hi <= 1'b0;
    end
  end

  // timer control bits
  always_ff @(posedge CLK_IN) begin
    if (SYS_RST_IN) begin
      ovf_ie <= 1'b0;
      cpwm <= 1'b0;
      run <= 1'b0;
    end else if (tsc_wr) begin
      ovf_ie <= wdata[IE_BIT];
      cpwm <= wdata[CPWM_BIT];
      run <= wdata[RUN_BIT];
    end
  end

  // wrap flag: read while set arms, zero write clears, new wrap wins
  always_ff @(posedge CLK_IN) begin
    if (SYS_RST_IN) begin
      ovf_flag <= 1'b0;
      ovf_armed <= 1'b0;
    end else begin
      if (tsc_rd && ovf_flag) begin
        ovf_armed <= 1'b1;
      end
      if (tsc_wr && ovf_armed && !wdata[FLAG_BIT]) begin
        ovf_flag <= 1'b0;
        ovf_armed <= 1'b0;
      end
      if (ovf_set) begin
        ovf_flag <= 1'b1; // see (RL2)
        ovf_armed <= 1'b0;
      end
    end
  end

  // coherent counter reads; the latch ignores reads while in debug
  always_ff @(posedge CLK_IN) begin
    if (SYS_RST_IN) begin
      cnt_latched <= 1'b0;
      cnt_first_hi <= 1'b0;
      cnt_buf <= CNT_ZERO;
    end else if (cnt_wr || tsc_wr) begin
      cnt_latched <= 1'b0;
    end else if (!DEBUG_MODE_IN && (cnt_rd_hi || cnt_rd_lo)) begin // see (RL1)
      if (!cnt_latched) begin
        cnt_latched <= 1'b1;
        cnt_first_hi <= cnt_rd_hi;
        cnt_buf <= cnt;
      end else if (cnt_rd_hi != cnt_first_hi) begin
        cnt_latched <= 1'b0;
      end
    end
  end
  assign cnt_view = cnt_latched ? cnt_buf : cnt;

  // channels
  for (genvar n = 0; n < NUM_CH; n++) begin : g_ch
    tmc_ch_ctrl_s ctrl;
    tmc_mode_e mode;
    logic [CNT_W-1:0] val;
    logic [DATA_W-1:0] vbuf_hi, vbuf_lo;
    logic flag, armed, vpend_hi, vpend_lo, pin_prev, pin_out;
    logic sc_wr, sc_rd, vhi_wr, vlo_wr, rise, fall, cap_edge, match;
    logic active_lvl;

    assign sc_wr = wr && ch_hit(addr, n, CH_OFF_SC);
    assign sc_rd = rd && ch_hit(addr, n, CH_OFF_SC);
    assign vhi_wr = wr && ch_hit(addr, n, CH_OFF_VAL_HI);
    assign vlo_wr = wr && ch_hit(addr, n, CH_OFF_VAL_LO);
    assign mode = ch_mode(cpwm, ctrl);
    assign rise = CH_PIN_IN[n] && !pin_prev;
    assign fall = !CH_PIN_IN[n] && pin_prev;

    // edge selection for capture; code 00 captures nothing
    always_comb begin
      case (ctrl.edge_level)
        ELS_01: cap_edge = rise; // see (RL19)
        ELS_10: cap_edge = fall; // see (RL19)
        ELS_11: cap_edge = rise || fall; // see (RL19)
        default: cap_edge = 1'b0; // see (RL17)
      endcase
    end

    // matches only count while the counter steps, so none in debug
    assign match = step && cnt == val;
    // see (RL6) (RL7) (RL8)
    assign ch_event[n] = (mode == MODE_CAPTURE) ? cap_edge : match;
    // code 10 gives high-true pulses, x1 low-true
    assign active_lvl = !ctrl.edge_level[0]; // see (RL16)

    // control bits; an sc write also drops any half-written value
    always_ff @(posedge CLK_IN) begin
      if (SYS_RST_IN) begin
        ctrl <= '0; // see (RL13)
      end else if (sc_wr) begin
        ctrl.irq_en <= wdata[IE_BIT]; // see (RL13)
        ctrl.mode_upper <= wdata[MS_UPPER_BIT];
        ctrl.mode_lower <= wdata[MS_LOWER_BIT];
        ctrl.edge_level <= wdata[ELS_HI_BIT:ELS_LO_BIT];
      end
    end

    // event flag with the read-then-write-zero clear
    always_ff @(posedge CLK_IN) begin
      if (SYS_RST_IN) begin
        flag <= 1'b0; // see (RL12)
        armed <= 1'b0;
      end else begin
        if (sc_rd && flag) begin
          armed <= 1'b1; // see (RL10)
        end
        // a one in the flag bit is ignored
        if (sc_wr && armed && !wdata[FLAG_BIT]) begin // see (RL10) (RL12)
          flag <= 1'b0;
          armed <= 1'b0;
        end
        if (ch_event[n]) begin
          flag <= 1'b1; // see (RL11)
          armed <= 1'b0;
        end
      end
    end

    // value: captured in capture mode, else two-byte coherent write
    always_ff @(posedge CLK_IN) begin
      if (SYS_RST_IN) begin
        val <= CNT_ZERO;
        vbuf_hi <= BYTE_ZERO;
        vbuf_lo <= BYTE_ZERO;
        vpend_hi <= 1'b0;
        vpend_lo <= 1'b0;
      end else if (sc_wr) begin
        vpend_hi <= 1'b0;
        vpend_lo <= 1'b0;
      end else if (mode == MODE_CAPTURE && cap_edge) begin
        val <= cnt; // see (RL6)
      end else if (vhi_wr) begin
        if (vpend_lo) begin
          val <= {wdata, vbuf_lo};
          vpend_lo <= 1'b0;
        end else begin
          vbuf_hi <= wdata;
          vpend_hi <= 1'b1;
        end
      end else if (vlo_wr) begin
        if (vpend_hi) begin
          val <= {vbuf_hi, wdata};
          vpend_hi <= 1'b0;
        end else begin
          vbuf_lo <= wdata;
          vpend_lo <= 1'b1;
        end
      end
    end

    // pin level per mode
    always_ff @(posedge CLK_IN) begin
      if (SYS_RST_IN) begin
        pin_prev <= 1'b0;
        pin_out <= 1'b0;
      end else begin
        pin_prev <= CH_PIN_IN[n];
        case (mode)
          MODE_COMPARE: begin
            if (match) begin
              case (ctrl.edge_level) // see (RL16)
                ELS_01: pin_out <= !pin_out;
                ELS_10: pin_out <= 1'b0;
                ELS_11: pin_out <= 1'b1;
                default: pin_out <= pin_out;
              endcase
            end
          end
          MODE_EDGE_PWM: begin
            // a wrap in the same cycle wins, giving full duty at terminal
            if (wrap_step) begin
              pin_out <= active_lvl;
            end else if (match) begin
              pin_out <= !active_lvl;
            end
          end
          MODE_CENTER_PWM: begin
            if (match) begin
              pin_out <= count_down ? active_lvl : !active_lvl;
            end
          end
          default: pin_out <= pin_out;
        endcase
      end
    end

    // released pin for code 00 and for capture inputs
    assign CH_PIN_OE_OUT[n] = ctrl.edge_level != ELS_OFF &&
                              mode != MODE_CAPTURE; // see (RL17)
    assign CH_PIN_OUT[n] = pin_out;
    assign CH_IRQ_OUT[n] = flag && ctrl.irq_en; // see (RL9)

    // register view of the channel
    always_comb begin
      ch_sc_rd[n] = BYTE_ZERO;
      ch_sc_rd[n][FLAG_BIT] = flag;
      ch_sc_rd[n][IE_BIT] = ctrl.irq_en;
      ch_sc_rd[n][MS_UPPER_BIT] = ctrl.mode_upper;
      ch_sc_rd[n][MS_LOWER_BIT] = ctrl.mode_lower;
      ch_sc_rd[n][ELS_HI_BIT:ELS_LO_BIT] = ctrl.edge_level;
    end
    assign ch_val_rd[n] = val;
  end

  // sticky event bits for the summary interrupt
  always_comb begin
    next_stat_set = BYTE_ZERO;
    next_stat_set[STAT_OVF_BIT] = ovf_set;
    for (int i = 0; i < NUM_CH; i++) begin
      next_stat_set[STAT_CH_BASE + i] = ch_event[i];
    end
  end

  // status clears on read, but an event in that cycle still lands
  always_ff @(posedge CLK_IN) begin
    if (SYS_RST_IN) begin
      irq_stat <= BYTE_ZERO;
    end else if (rd && addr == ADDR_IRQ_STAT) begin
      irq_stat <= next_stat_set;
    end else begin
      irq_stat <= irq_stat | next_stat_set;
    end
  end

  // interrupt mask
  always_ff @(posedge CLK_IN) begin
    if (SYS_RST_IN) begin
      irq_mask <= BYTE_ZERO;
    end else if (wr && addr == ADDR_IRQ_MASK) begin
      irq_mask <= wdata;
    end
  end

  // read mux; unmapped addresses read zero
  always_comb begin
    next_rd = BYTE_ZERO;
    if (addr == ADDR_TSC) begin
      next_rd[FLAG_BIT] = ovf_flag;
      next_rd[IE_BIT] = ovf_ie;
      next_rd[CPWM_BIT] = cpwm;
      next_rd[RUN_BIT] = run;
    end else if (addr == ADDR_CNT_HI) begin
      next_rd = cnt_view[CNT_W-1:DATA_W];
    end else if (addr == ADDR_CNT_LO) begin
      next_rd = cnt_view[DATA_W-1:0];
    end else if (addr == ADDR_MOD_HI) begin
      next_rd = mod[CNT_W-1:DATA_W];
    end else if (addr == ADDR_MOD_LO) begin
      next_rd = mod[DATA_W-1:0];
    end else if (addr == ADDR_IRQ_STAT) begin
      next_rd = irq_stat;
    end else if (addr == ADDR_IRQ_MASK) begin
      next_rd = irq_mask;
    end else begin
      for (int i = 0; i < NUM_CH; i++) begin
        if (ch_hit(addr, i, CH_OFF_SC)) begin
          next_rd = ch_sc_rd[i];
        end else if (ch_hit(addr, i, CH_OFF_VAL_HI)) begin
          next_rd = ch_val_rd[i][CNT_W-1:DATA_W];
        end else if (ch_hit(addr, i, CH_OFF_VAL_LO)) begin
          next_rd = ch_val_rd[i][DATA_W-1:0];
        end
      end
    end
  end

  // read data stand only in the cycle after the strobe
  always_ff @(posedge CLK_IN) begin
    if (SYS_RST_IN) begin
      rd_data <= BYTE_ZERO;
    end else begin
      rd_data <= rd ? next_rd : BYTE_ZERO;
    end
  end

  assign RD_DATA_OUT = rd_data;
  assign OVF_IRQ_OUT = ovf_flag && ovf_ie;
  assign IRQ_OUT = |(irq_stat & irq_mask);
endmodule : tmc_timer_core

// File: test/tmc_timer_monitor.sv
// Purpose: port-level checker for the timer core, channel 0 view
// Assumes: channel 0 control is shadowed from bus writes
// Notes: bound into every instance of the core
module tmc_timer_monitor #(
  parameter int NUM_CH = 2
) (
  input wire logic CLK_IN,
  input wire logic SYS_RST_IN,
  input wire logic DEBUG_MODE_IN,
  input wire tmc_pkg::tmc_bus_req_s BUS_IN,
  input wire logic [tmc_pkg::DATA_W-1:0] RD_DATA_OUT,
  input wire logic [NUM_CH-1:0] CH_PIN_IN,
  input wire logic [NUM_CH-1:0] CH_PIN_OUT,
  input wire logic [NUM_CH-1:0] CH_PIN_OE_OUT,
  input wire logic [NUM_CH-1:0] CH_IRQ_OUT,
  input wire logic OVF_IRQ_OUT,
  input wire logic IRQ_OUT
);
  import tmc_pkg::*;
  logic [7:0] sc0;
  logic cpwm;
  logic sc_wr;
  logic cap;

  // decode of channel 0 control writes and live capture mode
  assign sc_wr = BUS_IN.wr && BUS_IN.addr == ADDR_CH_BASE;
  assign cap = !cpwm && sc0[5:4] == 2'h0 && sc0[IE_BIT];

  // shadow of channel 0 control; irq equals flag only while ie is set
  always_ff @(posedge CLK_IN) begin
    if (SYS_RST_IN) begin
      sc0 <= BYTE_ZERO;
    end else if (sc_wr) begin
      sc0 <= BUS_IN.wdata;
    end
  end

  // shadow of the center pwm select
  always_ff @(posedge CLK_IN) begin
    if (SYS_RST_IN) begin
      cpwm <= 1'b0;
    end else if (BUS_IN.wr && BUS_IN.addr == ADDR_TSC) begin
      cpwm <= BUS_IN.wdata[CPWM_BIT];
    end
  end

  default clocking @(posedge CLK_IN); endclocking
  default disable iff (SYS_RST_IN);

  a_oe_mode_map: assert property (
    CH_PIN_OE_OUT[0] == (sc0[3:2] != 2'h0 && (cpwm || sc0[5:4] != 2'h0)))
    else $error("pin enable does not follow channel mode");
  a_ie_gates_irq: assert property (
    sc_wr && !BUS_IN.wdata[IE_BIT] |=> !CH_IRQ_OUT[0])
    else $error("channel irq raised with enable clear");
  a_rst_quiet: assert property (
    $fell(SYS_RST_IN) |-> CH_IRQ_OUT == '0 && !OVF_IRQ_OUT
      && CH_PIN_OE_OUT == '0)
    else $error("outputs not quiet after reset");
  a_debug_freeze: assert property (
    $past(DEBUG_MODE_IN) && !$past(BUS_IN.wr)
      |-> $stable(CH_PIN_OUT) && $stable(OVF_IRQ_OUT))
    else $error("timer moved during debug");
  a_cap_rise: assert property (
    cap && sc0[ELS_LO_BIT] && $rose(CH_PIN_IN[0]) |-> ##[1:2] CH_IRQ_OUT[0])
    else $error("rising capture edge missed");
  a_cap_fall: assert property (
    cap && sc0[ELS_HI_BIT] && $fell(CH_PIN_IN[0]) |-> ##[1:2] CH_IRQ_OUT[0])
    else $error("falling capture edge missed");
  a_cap_ignore: assert property (
    cap && sc0[3:2] == ELS_01 && !CH_IRQ_OUT[0] && $fell(CH_PIN_IN[0])
      && $past(CH_PIN_IN[0], 2) |=> !CH_IRQ_OUT[0])
    else $error("falling edge captured in rising mode");
  a_flag_wr_one: assert property (
    sc_wr && BUS_IN.wdata == 8'hC0 && sc0 == 8'h40 && !cpwm
      && !CH_IRQ_OUT[0] |=> !CH_IRQ_OUT[0])
    else $error("writing one set the event flag");

  c_capture: cover property (cap && $rose(CH_IRQ_OUT[0]));
  c_wrap: cover property ($rose(OVF_IRQ_OUT));
  c_pin_drive: cover property ($rose(CH_PIN_OUT[0]));
endmodule : tmc_timer_monitor

bind tmc_timer_core tmc_timer_monitor #(.NUM_CH(NUM_CH)) u_monitor (
  .CLK_IN(CLK_IN),
  .SYS_RST_IN(SYS_RST_IN),
  .DEBUG_MODE_IN(DEBUG_MODE_IN),
  .BUS_IN(BUS_IN),
  .RD_DATA_OUT(RD_DATA_OUT),
  .CH_PIN_IN(CH_PIN_IN),
  .CH_PIN_OUT(CH_PIN_OUT),
  .CH_PIN_OE_OUT(CH_PIN_OE_OUT),
  .CH_IRQ_OUT(CH_IRQ_OUT),
  .OVF_IRQ_OUT(OVF_IRQ_OUT),
  .IRQ_OUT(IRQ_OUT)
);

// File: test/tmc_pin_src.sv
// Purpose: outside signal source on the timer channel pins
// Assumes: source level changes are held for several cycles
// Notes: lag of 1..4 cycles models a prompt or a slow source
module tmc_pin_src #(
  parameter int NUM_CH = 2
) (
  input wire logic clk_in,
  input wire logic [NUM_CH-1:0] level_in,
  input wire logic [1:0] lag_in,
  input wire logic [NUM_CH-1:0] drive_in,
  input wire logic [NUM_CH-1:0] oe_in,
  output logic [NUM_CH-1:0] pin_out
);
  logic [NUM_CH-1:0] stage [4];

  // delay line for the source level
  always_ff @(posedge clk_in) begin
    stage[0] <= level_in;
    stage[1] <= stage[0];
    stage[2] <= stage[1];
    stage[3] <= stage[2];
  end

  // wire level: the timer wins while it drives, else the source
  always_comb begin
    pin_out = (oe_in & drive_in) | (~oe_in & stage[lag_in]);
  end
endmodule : tmc_pin_src

// File: test/timer_modulo_channel_control_tb.sv
// Purpose: self-checking bench for the timer modulo and channel block
// Assumes: reads are answered exactly one cycle after the strobe
// Notes: reads queue their expectation; a watcher compares answers
module timer_modulo_channel_control_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import tmc_pkg::*;
  localparam logic [5:0] SC0 = ADDR_CH_BASE;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic dbg = 1'b0;
  tmc_bus_req_s bus = '0;
  logic [7:0] rd_data;
  logic [1:0] pin_in, pin_out, pin_oe, ch_irq, level = 2'h0;
  logic [1:0] lag = 2'h0;
  logic ovf_irq, irq, rd_seen = 1'b0;
  logic [7:0] exp_q [$];
  logic [7:0] e_now, ctl, val;
  int n_mismatch = 0;
  int total_checks = 0;
  int seed = 32'h107F82BD;
  int k, ones;

`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin \
  n_mismatch++; $display("[FAIL] %0t got %0h exp %0h", $time, g, e); \
  end end

  // free-running clock
  always #5 clk = ~clk;

  tmc_timer_core #(.NUM_CH(2)) dut (.CLK_IN(clk), .SYS_RST_IN(rst),
    .DEBUG_MODE_IN(dbg), .BUS_IN(bus), .RD_DATA_OUT(rd_data),
    .CH_PIN_IN(pin_in), .CH_PIN_OUT(pin_out), .CH_PIN_OE_OUT(pin_oe),
    .CH_IRQ_OUT(ch_irq), .OVF_IRQ_OUT(ovf_irq), .IRQ_OUT(irq));

  tmc_pin_src #(.NUM_CH(2)) u_src (.clk_in(clk), .level_in(level),
    .lag_in(lag), .drive_in(pin_out), .oe_in(pin_oe), .pin_out(pin_in));

  // read answers stand one cycle only, so compare in exactly that cycle
  always @(posedge clk) begin
    if (rd_seen) begin
      e_now = exp_q.pop_front();
      `CHK(rd_data, e_now)
    end
    rd_seen <= bus.rd;
  end

  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    @(posedge clk);
    bus <= '{1'b1, 1'b0, a, d};
    @(posedge clk);
    bus <= '0;
  endtask : wr

  task automatic rd(input logic [5:0] a, input logic [7:0] e);
    @(posedge clk);
    bus <= '{1'b0, 1'b1, a, BYTE_ZERO};
    exp_q.push_back(e);
    @(posedge clk);
    bus <= '0;
  endtask : rd

  // bounded wait for the channel irq or the wrap irq
  task automatic wait_hi(input logic ovf, input int n);
    int j;
    for (j = 0; j < n; j++) begin
      if ((ovf ? ovf_irq : ch_irq[0]) === 1'b1) break;
      @(posedge clk);
    end
  endtask : wait_hi

  task automatic drive_pin(input logic lv);
    @(posedge clk);
    level[0] <= lv;
    repeat (8) @(posedge clk);
  endtask : drive_pin

  // one capture edge, then the read-then-write-zero clear
  task automatic edge_chk(input logic lv, input logic hit);
    drive_pin(lv);
    `CHK(ch_irq[0], hit)
    `CHK(irq, hit)
    if (hit) begin
      rd(ADDR_IRQ_STAT, 8'h02);
      rd(SC0, ctl | 8'h80);
      wr(SC0, ctl);
    end
    @(posedge clk);
    `CHK(ch_irq[0], 1'b0)
    `CHK(irq, 1'b0)
  endtask : edge_chk

  task automatic stop_test;
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : stop_test

  // watchdog, far beyond the fewer than two thousand cycles the run needs
  initial begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    stop_test();
  end

  // main sequence
  initial begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    rd(ADDR_MOD_HI, 8'h00);
    rd(ADDR_MOD_LO, 8'h00);
    rd(SC0, 8'h00);
    rd(6'h3F, 8'h00);
    wr(SC0, 8'h40);
    wr(SC0, 8'hC0);
    rd(SC0, 8'h40);
    wr(ADDR_IRQ_MASK, 8'h02);
    for (k = 1; k < 4; k++) begin
      lag <= 2'($random(seed));
      ctl = 8'h40 | 8'(k << 2);
      wr(SC0, ctl);
      edge_chk(1'b1, k != 2);
      edge_chk(1'b0, k != 1);
    end
    // clear without a read, then an event in mid-clear
    wr(ADDR_IRQ_MASK, 8'h00);
    drive_pin(1'b1);
    wr(SC0, ctl);
    @(posedge clk);
    `CHK(ch_irq[0], 1'b1)
    `CHK(irq, 1'b0)
    rd(SC0, 8'hCC);
    drive_pin(1'b0);
    wr(SC0, ctl);
    @(posedge clk);
    `CHK(ch_irq[0], 1'b1)
    rd(SC0, 8'hCC);
    wr(SC0, ctl);
    @(posedge clk);
    `CHK(ch_irq[0], 1'b0)
    wr(SC0, 8'h40);
    drive_pin(1'b1);
    `CHK(ch_irq[0], 1'b0)
    // output compare with a random value below the terminal count
    val = 8'h03 + (8'($random(seed)) % 8'h1B); // center matches 6+ apart
    wr(ADDR_MOD_HI, 8'h00);
    wr(ADDR_MOD_LO, 8'h20);
    wr(SC0 + CH_OFF_VAL_HI, 8'h00);
    wr(SC0 + CH_OFF_VAL_LO, val);
    wr(SC0, 8'h54);
    wr(ADDR_TSC, 8'h01);
    wait_hi(1'b0, 40);
    `CHK(ch_irq[0], 1'b1)
    repeat (2) @(posedge clk);
    `CHK(pin_out[0], 1'b1)
    `CHK(pin_oe[0], 1'b1)
    wr(SC0, 8'h10);
    // wrap flag and its suppression by a half-written terminal value
    wr(ADDR_TSC, 8'h41);
    wait_hi(1'b1, 40);
    `CHK(ovf_irq, 1'b1)
    rd(ADDR_TSC, 8'hC1);
    wr(ADDR_TSC, 8'h41);
    wr(ADDR_MOD_HI, 8'h00);
    repeat (100) @(posedge clk);
    `CHK(ovf_irq, 1'b0)
    wr(ADDR_MOD_LO, 8'h20);
    wait_hi(1'b1, 40);
    `CHK(ovf_irq, 1'b1)
    rd(ADDR_TSC, 8'hC1);
    wr(ADDR_TSC, 8'h01);
    // edge-aligned pwm must both drive and release within a period
    wr(SC0, 8'h68);
    ones = 0;
    for (k = 0; k < 40; k++) begin
      @(posedge clk);
      ones += int'(pin_out[0]);
    end
    `CHK(ones > 0 && ones < 40, 1'b1)
    `CHK(pin_oe[0], 1'b1)
    wr(ADDR_TSC, 8'h20); // stop in center mode, so no capture window
    rd(SC0, 8'hE8);
    wr(SC0, 8'h44);
    wr(ADDR_TSC, 8'h21);
    `CHK(pin_oe[0], 1'b1)
    wait_hi(1'b0, 80);
    `CHK(ch_irq[0], 1'b1)
    rd(SC0, 8'hC4);
    wr(SC0, 8'h44);
    @(posedge clk);
    `CHK(ch_irq[0], 1'b0)
    wait_hi(1'b0, 70);
    `CHK(ch_irq[0], 1'b1)
    // free run from zero, then freeze in debug
    wr(ADDR_TSC, 8'h01);
    wr(ADDR_MOD_HI, 8'h00);
    wr(ADDR_MOD_LO, 8'h00);
    wr(ADDR_CNT_LO, 8'h00);
    repeat (300) @(posedge clk);
    dbg <= 1'b1;
    repeat (2) @(posedge clk);
    rd(ADDR_CNT_HI, 8'h01);
    repeat (300) @(posedge clk);
    rd(ADDR_CNT_HI, 8'h01);
    dbg <= 1'b0;
    repeat (300) @(posedge clk);
    rd(ADDR_CNT_HI, 8'h02);
    rd(ADDR_CNT_LO, 8'h59);
    // channel 1 is never enabled, so it neither drives nor interrupts
    `CHK({ch_irq[1], pin_oe[1]}, 2'h0)
    repeat (3) @(posedge clk);
    stop_test();
  end
endmodule : timer_modulo_channel_control_tb
